// [design/hufc_device.sv]
// fifo, serial engine and device end of the flow-controlled link
`timescale 1ns/10ps

// =====================================================================
// fifo
module hufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [AW:0] count_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem[rptr_r];
    assign count_o = cnt_r;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // depth is a power of two so pointers wrap by overflow
    always_comb begin
        wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
        rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wptr_r] <= in_data_i;
        end
    end
endmodule

// =====================================================================
// serial engine, shared by both ends
module hufc_uart_core (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [hufc_pkg::DIV_W-1:0] baud_div_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic tx_allow_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic txd_o,
    input wire logic rxd_i,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_perr_o,
    output logic rx_ferr_o
);
    hufc_pkg::hufc_bit_state_t tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
    logic [hufc_pkg::DIV_W-1:0] div_c, tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt, rx_data_nxt;
    logic [2:0] tx_bit_r, tx_bit_nxt, rx_bit_r, rx_bit_nxt;
    logic txd_r, txd_nxt, tx_par_r, tx_par_nxt;
    logic rx_valid_nxt, rx_perr_nxt, rx_ferr_nxt, rx_phold_r, rx_phold_nxt;

    // one divisor for both directions, so a bit lasts exactly div cycles
    assign div_c = hufc_pkg::clamp_div(baud_div_i);
    assign txd_o = txd_r;

    // =================================================================
    // transmitter
    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_sh_nxt = tx_sh_r;
        tx_bit_nxt = tx_bit_r;
        tx_par_nxt = tx_par_r;
        txd_nxt = txd_r;
        tx_ready_o = 1'b0;
        if (tx_cnt_r != '0) begin
            tx_cnt_nxt = tx_cnt_r - 1'b1;
        end
        case (tx_st_r)
            hufc_pkg::BS_IDLE: begin
                // a frame in flight always completes; the gate acts between frames
                tx_ready_o = tx_allow_i;
                if (tx_valid_i && tx_allow_i) begin
                    tx_st_nxt = hufc_pkg::BS_START;
                    tx_cnt_nxt = div_c - 1'b1;
                    tx_sh_nxt = tx_data_i;
                    tx_par_nxt = hufc_pkg::par_bit(tx_data_i, parity_odd_i);
                    txd_nxt = hufc_pkg::LINE_START;
                end
            end
            hufc_pkg::BS_START: begin
                if (tx_cnt_r == '0) begin
                    tx_st_nxt = hufc_pkg::BS_DATA;
                    tx_cnt_nxt = div_c - 1'b1;
                    tx_bit_nxt = '0;
                    txd_nxt = tx_sh_r[0];
                    tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                end
            end
            hufc_pkg::BS_DATA: begin
                if (tx_cnt_r == '0) begin
                    tx_cnt_nxt = div_c - 1'b1;
                    if (tx_bit_r == 3'h7) begin
                        tx_st_nxt = parity_en_i ? hufc_pkg::BS_PARITY : hufc_pkg::BS_STOP;
                        txd_nxt = parity_en_i ? tx_par_r : hufc_pkg::LINE_IDLE;
                    end else begin
                        tx_bit_nxt = tx_bit_r + 1'b1;
                        txd_nxt = tx_sh_r[0];
                        tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                    end
                end
            end
            hufc_pkg::BS_PARITY: begin
                if (tx_cnt_r == '0) begin
                    tx_st_nxt = hufc_pkg::BS_STOP;
                    tx_cnt_nxt = div_c - 1'b1;
                    txd_nxt = hufc_pkg::LINE_IDLE;
                end
            end
            hufc_pkg::BS_STOP: begin
                if (tx_cnt_r == '0) begin
                    tx_st_nxt = hufc_pkg::BS_IDLE;
                end
            end
            default: begin
                tx_st_nxt = hufc_pkg::BS_IDLE;
                txd_nxt = hufc_pkg::LINE_IDLE;
            end
        endcase
    end

    // =================================================================
    // receiver, samples each bit at its middle
    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_sh_nxt = rx_sh_r;
        rx_bit_nxt = rx_bit_r;
        rx_phold_nxt = rx_phold_r;
        rx_data_nxt = rx_data_o;
        rx_valid_nxt = 1'b0;
        rx_perr_nxt = 1'b0;
        rx_ferr_nxt = 1'b0;
        if (rx_cnt_r != '0) begin
            rx_cnt_nxt = rx_cnt_r - 1'b1;
        end
        case (rx_st_r)
            hufc_pkg::BS_IDLE: begin
                rx_phold_nxt = 1'b0;
                if (rxd_i == hufc_pkg::LINE_START) begin
                    rx_st_nxt = hufc_pkg::BS_START;
                    rx_cnt_nxt = div_c >> 1;
                end
            end
            hufc_pkg::BS_START: begin
                // a glitch shorter than half a bit is not a start
                if (rx_cnt_r == '0) begin
                    rx_st_nxt = (rxd_i == hufc_pkg::LINE_START) ?
                        hufc_pkg::BS_DATA : hufc_pkg::BS_IDLE;
                    rx_cnt_nxt = div_c - 1'b1;
                    rx_bit_nxt = '0;
                end
            end
            hufc_pkg::BS_DATA: begin
                if (rx_cnt_r == '0) begin
                    rx_sh_nxt = {rxd_i, rx_sh_r[7:1]};
                    rx_cnt_nxt = div_c - 1'b1;
                    rx_bit_nxt = rx_bit_r + 1'b1;
                    if (rx_bit_r == 3'h7) begin
                        rx_st_nxt = parity_en_i ? hufc_pkg::BS_PARITY : hufc_pkg::BS_STOP;
                    end
                end
            end
            hufc_pkg::BS_PARITY: begin
                if (rx_cnt_r == '0) begin
                    rx_phold_nxt = rxd_i != hufc_pkg::par_bit(rx_sh_r, parity_odd_i);
                    rx_st_nxt = hufc_pkg::BS_STOP;
                    rx_cnt_nxt = div_c - 1'b1;
                end
            end
            hufc_pkg::BS_STOP: begin
                if (rx_cnt_r == '0) begin
                    rx_st_nxt = hufc_pkg::BS_IDLE;
                    rx_valid_nxt = 1'b1;
                    rx_data_nxt = rx_sh_r;
                    rx_perr_nxt = rx_phold_r;
                    rx_ferr_nxt = rxd_i != hufc_pkg::LINE_IDLE;
                end
            end
            default: begin
                rx_st_nxt = hufc_pkg::BS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_st_r <= hufc_pkg::BS_IDLE;
            tx_cnt_r <= '0;
            tx_sh_r <= 8'h00;
            tx_bit_r <= 3'h0;
            tx_par_r <= 1'b0;
            txd_r <= 1'b1;
            rx_st_r <= hufc_pkg::BS_IDLE;
            rx_cnt_r <= '0;
            rx_sh_r <= 8'h00;
            rx_bit_r <= 3'h0;
            rx_phold_r <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
            rx_perr_o <= 1'b0;
            rx_ferr_o <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_par_r <= tx_par_nxt;
            txd_r <= txd_nxt;
            rx_st_r <= rx_st_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_phold_r <= rx_phold_nxt;
            rx_valid_o <= rx_valid_nxt;
            rx_data_o <= rx_data_nxt;
            rx_perr_o <= rx_perr_nxt;
            rx_ferr_o <= rx_ferr_nxt;
        end
    end
endmodule

// =====================================================================
// device end
module hufc_device (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [hufc_pkg::DIV_W-1:0] baud_div_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    output logic rx_perr_o,
    output logic rx_ferr_o,
    output logic rx_ovr_o,
    hufc_link_if.dev_mp link
);
    logic q_valid, q_ready, c_rx_valid, rx_in_ready, rts_r, rts_nxt, ovr_r, ovr_nxt;
    logic [7:0] q_data, c_rx_data;
    logic [6:0] rx_count;

    hufc_fifo #(.WIDTH(8), .DEPTH(hufc_pkg::TX_DEPTH)) u_tx_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_data),
        .count_o()
    );

    hufc_uart_core u_core (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .baud_div_i(baud_div_i),
        .parity_en_i(parity_en_i),
        .parity_odd_i(parity_odd_i),
        .tx_allow_i(!link.host_cts),
        .tx_valid_i(q_valid),
        .tx_data_i(q_data),
        .tx_ready_o(q_ready),
        .txd_o(link.d2h_txd),
        .rxd_i(link.h2d_txd),
        .rx_valid_o(c_rx_valid),
        .rx_data_o(c_rx_data),
        .rx_perr_o(rx_perr_o),
        .rx_ferr_o(rx_ferr_o)
    );

    // deep buffer: stop level at one quarter leaves far more than 16 bytes free
    hufc_fifo #(.WIDTH(8), .DEPTH(hufc_pkg::DEV_RX_DEPTH)) u_rx_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(c_rx_valid),
        .in_data_i(c_rx_data),
        .in_ready_o(rx_in_ready),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o),
        .count_o(rx_count)
    );

    always_comb begin
        rts_nxt = rx_count >= hufc_pkg::DEV_RTS_LEVEL;
        ovr_nxt = c_rx_valid && !rx_in_ready;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rts_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            rts_r <= rts_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    assign link.dev_rts = rts_r;
    assign rx_ovr_o = ovr_r;
endmodule

// [design/hufc_host.sv]
// host end of the flow-controlled link
`timescale 1ns/10ps
module hufc_host (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [hufc_pkg::DIV_W-1:0] baud_div_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    output logic rx_perr_o,
    output logic rx_ferr_o,
    output logic rx_ovr_o,
    hufc_link_if.host_mp link
);
    logic q_valid, q_ready, c_rx_valid, rx_in_ready, cts_r, cts_nxt, ovr_r, ovr_nxt;
    logic [7:0] q_data, c_rx_data;
    logic [3:0] rx_count;
    logic [hufc_pkg::DIV_W-1:0] hold_r, hold_nxt;

    hufc_fifo #(.WIDTH(8), .DEPTH(hufc_pkg::TX_DEPTH)) u_tx_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_data),
        .count_o()
    );

    // checked before each frame, so at most one byte follows a stop request
    hufc_uart_core u_core (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .baud_div_i(baud_div_i),
        .parity_en_i(parity_en_i),
        .parity_odd_i(parity_odd_i),
        .tx_allow_i(!link.dev_rts),
        .tx_valid_i(q_valid),
        .tx_data_i(q_data),
        .tx_ready_o(q_ready),
        .txd_o(link.h2d_txd),
        .rxd_i(link.d2h_txd),
        .rx_valid_o(c_rx_valid),
        .rx_data_o(c_rx_data),
        .rx_perr_o(rx_perr_o),
        .rx_ferr_o(rx_ferr_o)
    );

    hufc_fifo #(.WIDTH(8), .DEPTH(hufc_pkg::HOST_RX_DEPTH)) u_rx_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(c_rx_valid),
        .in_data_i(c_rx_data),
        .in_ready_o(rx_in_ready),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o),
        .count_o(rx_count)
    );

    // =================================================================
    // stop request, held for at least one bit time once raised
    always_comb begin
        cts_nxt = cts_r;
        hold_nxt = hold_r;
        ovr_nxt = c_rx_valid && !rx_in_ready;
        if (!cts_r) begin
            if (rx_count >= hufc_pkg::HOST_CTS_LEVEL) begin
                cts_nxt = 1'b1;
                hold_nxt = hufc_pkg::clamp_div(baud_div_i) - 1'b1;
            end
        end else if (hold_r != '0) begin
            hold_nxt = hold_r - 1'b1;
        end else if (rx_count < hufc_pkg::HOST_CTS_LEVEL) begin
            cts_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cts_r <= 1'b0;
            hold_r <= '0;
            ovr_r <= 1'b0;
        end else begin
            cts_r <= cts_nxt;
            hold_r <= hold_nxt;
            ovr_r <= ovr_nxt;
        end
    end

    assign link.host_cts = cts_r;
    assign rx_ovr_o = ovr_r;
endmodule

// [design/hufc_link_if.sv]
// serial link wires between the device end and the host end
`timescale 1ns/10ps
interface hufc_link_if;
    logic d2h_txd;
    logic h2d_txd;
    logic dev_rts;
    logic host_cts;

    modport dev_mp (output d2h_txd, output dev_rts, input h2d_txd, input host_cts);
    modport host_mp (output h2d_txd, output host_cts, input d2h_txd, input dev_rts);
endinterface

// [design/hufc_pkg.sv]
// shared constants, types and helpers for the flow-controlled serial link
// =====================================================================
package hufc_pkg;
    // =================================================================
    // clock and bit timing
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD_MIN_BPS = 37_500;
    localparam int BAUD_MAX_BPS = 4_000_000;
    localparam int DIV_W = 16;
    // slowest rate rounds down, fastest rounds up to whole cycles
    localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN_BPS);
    localparam logic [DIV_W-1:0] DIV_MIN =
        DIV_W'((CLK_HZ + BAUD_MAX_BPS - 1) / BAUD_MAX_BPS);
    // =================================================================
    // frame and buffers
    localparam int DATA_BITS = 8;
    localparam int TX_DEPTH = 8;
    localparam int DEV_RX_DEPTH = 64;
    localparam int HOST_RX_DEPTH = 8;
    localparam int HOST_STOP_BYTES = 16;
    localparam logic [6:0] DEV_RTS_LEVEL = 7'(DEV_RX_DEPTH / 4);
    localparam logic [3:0] HOST_CTS_LEVEL = 4'h4;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic LINE_START = 1'b0;

    typedef enum {BS_IDLE, BS_START, BS_DATA, BS_PARITY, BS_STOP} hufc_bit_state_t;

    // =================================================================
    // helpers
    function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
        if (d < DIV_MIN) begin
            return DIV_MIN;
        end else if (d > DIV_MAX) begin
            return DIV_MAX;
        end
        return d;
    endfunction

    function automatic logic par_bit(input logic [DATA_BITS-1:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction
endpackage

// [sim/hufc_link_sva.sv]
// checker for reset idle state, bit timing and flow control on the link wires
`timescale 1ns/10ps
module hufc_link_sva #(
    parameter int DIV = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic d2h_txd,
    input wire logic h2d_txd,
    input wire logic dev_rts,
    input wire logic host_cts
);
    // longer than any high run inside a frame, so a fall after it is a fresh start
    localparam int IDLE = 11 * DIV;
    // longest frame plus the start latency of a frame already committed
    localparam int HOLD = 12 * DIV;
    logic [7:0] cts_r, cts_nxt, rts_r, rts_nxt, di_r, di_nxt, hi_r, hi_nxt;

    // saturating run length of a high level
    function automatic logic [7:0] run(input logic c, input logic [7:0] v);
        return c ? ((v == 8'hff) ? v : v + 8'h01) : 8'h00;
    endfunction

    always_comb begin
        cts_nxt = run(host_cts, cts_r);
        rts_nxt = run(dev_rts, rts_r);
        di_nxt = run(d2h_txd, di_r);
        hi_nxt = run(h2d_txd, hi_r);
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cts_r <= 8'h00;
            rts_r <= 8'h00;
            di_r <= 8'h00;
            hi_r <= 8'h00;
        end else begin
            cts_r <= cts_nxt;
            rts_r <= rts_nxt;
            di_r <= di_nxt;
            hi_r <= hi_nxt;
        end
    end

    // ====================================================
    // assertions
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_reset_idle_lines: assert property ($rose(reset_n_i) |-> d2h_txd && h2d_txd && !dev_rts && !host_cts)
        else $error("link not idle after reset");
    a_d2h_bit_len: assert property ($changed(d2h_txd) |=> $stable(d2h_txd) [*7])
        else $error("device bit shorter than nominal");
    a_h2d_bit_len: assert property ($changed(h2d_txd) |=> $stable(h2d_txd) [*7])
        else $error("host bit shorter than nominal");
    a_cts_min_high: assert property ($rose(host_cts) |-> host_cts [*8])
        else $error("stop pulse shorter than one bit");
    a_dev_stops_cts: assert property (cts_r >= HOLD |-> d2h_txd)
        else $error("device still sending under stop");
    a_host_stops_rts: assert property (rts_r >= HOLD |-> h2d_txd)
        else $error("host still sending under stop");
    // gate is read only at the launching edge: one sample back, not older
    a_start_cts_low: assert property ($fell(d2h_txd) && di_r >= IDLE
        |-> !$past(host_cts))
        else $error("device frame started under stop");
    a_start_rts_low: assert property ($fell(h2d_txd) && hi_r >= IDLE
        |-> !$past(dev_rts))
        else $error("host frame started under stop");
endmodule

// [sim/tb_host_uart_flow_control.sv]
// self-checking bench for the two link ends joined back to back
`timescale 1ns/10ps
module tb_host_uart_flow_control;
    localparam int DIV = 8;
    logic sys_clk_i = 1'b0;
    logic reset_n_i;
    logic [1:0] tx_v, rx_r, pen, podd, tx_rdy, rx_v, perr, ferr, ovr;
    logic [7:0] tx_d [2];
    logic [7:0] rx_d [2];
    // index 0 is the device end, 1 the host end
    logic [7:0] exp_q [2][$];
    logic [7:0] wq [2][$];
    logic [31:0] seed = 32'h659f;
    int fail_count = 0;
    int total_checks = 0;
    int frames [2] = '{0, 0};
    int fr_at = 0, base = 0, perr_cnt = 0, bad_cnt = 0, cyc = 0;

    hufc_link_if lnk();
    hufc_device i_hufc_device (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .baud_div_i(hufc_pkg::DIV_W'(DIV)),
        .parity_en_i(pen[0]), .parity_odd_i(podd[0]), .tx_valid_i(tx_v[0]),
        .tx_data_i(tx_d[0]), .tx_ready_o(tx_rdy[0]), .rx_valid_o(rx_v[0]),
        .rx_data_o(rx_d[0]), .rx_ready_i(rx_r[0]), .rx_perr_o(perr[0]),
        .rx_ferr_o(ferr[0]), .rx_ovr_o(ovr[0]), .link(lnk));
    hufc_host i_hufc_host (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .baud_div_i(hufc_pkg::DIV_W'(DIV)),
        .parity_en_i(pen[1]), .parity_odd_i(podd[1]), .tx_valid_i(tx_v[1]),
        .tx_data_i(tx_d[1]), .tx_ready_o(tx_rdy[1]), .rx_valid_o(rx_v[1]),
        .rx_data_o(rx_d[1]), .rx_ready_i(rx_r[1]), .rx_perr_o(perr[1]),
        .rx_ferr_o(ferr[1]), .rx_ovr_o(ovr[1]), .link(lnk));
    hufc_link_sva #(.DIV(DIV)) i_hufc_link_sva (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .d2h_txd(lnk.d2h_txd),
        .h2d_txd(lnk.h2d_txd), .dev_rts(lnk.dev_rts), .host_cts(lnk.host_cts));

    always #20 sys_clk_i = ~sys_clk_i;

    // ====================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic par_exp(input logic [7:0] d, input logic odd);
        return (^d) ^ odd;
    endfunction

    function automatic logic line(input bit e);
        return e ? lnk.h2d_txd : lnk.d2h_txd;
    endfunction

    task automatic tick(input int n, input int d = 2);
        repeat (n) @(posedge sys_clk_i);
        #d;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // valid stays up across the burst, so bytes go back to back
    task automatic burst(input bit e, input int n);
        int k, w;
        logic [7:0] b;
        for (k = 0; k < n; k++) begin
            seed = lfsr(seed);
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : seed[7:0];
            tx_d[e] = b;
            tx_v[e] = 1'b1;
            w = 0;
            while (tx_rdy[e] !== 1'b1 && w < 9000) begin
                tick(1, 1);
                w++;
            end
            cmp("tx_accept", 0, w >= 9000);
            tick(1, 1);
            exp_q[!e].push_back(b);
            wq[e].push_back(b);
        end
        tx_v[e] = 1'b0;
    endtask

    task automatic drain();
        int w;
        w = 0;
        while (exp_q[0].size() + exp_q[1].size() + wq[0].size() + wq[1].size() != 0
               && w < 8000) begin
            tick(1, 1);
            w++;
        end
        tick(4 * DIV, 1);
        cmp("drained", 0, w >= 8000);
        cmp("rx_empty", 0, rx_v);
    endtask

    // wire decoder, sampling mid-bit at the nominal rate
    task automatic mon(input bit e);
        logic [7:0] b;
        int i;
        forever begin
            tick(1);
            if (line(e) === 1'b0) begin
                frames[e]++;
                tick(DIV / 2);
                cmp("start_bit", 0, line(e));
                for (i = 0; i < 8; i++) begin
                    tick(DIV);
                    b[i] = line(e);
                end
                if (pen[e]) begin
                    tick(DIV);
                    cmp("parity_bit", par_exp(b, podd[e]), line(e));
                end
                tick(DIV);
                cmp("stop_bit", 1, line(e));
                cmp("wire_byte", (wq[e].size() > 0) ? wq[e].pop_front() : 9'h100, b);
            end
        end
    endtask

    task automatic popper(input bit e);
        forever begin
            tick(1);
            if (rx_r[e] === 1'b1 && rx_v[e] === 1'b1) begin
                cmp("rx_byte", (exp_q[e].size() > 0) ? exp_q[e].pop_front() : 9'h100, rx_d[e]);
            end
        end
    endtask

    task automatic flags();
        forever begin
            tick(1);
            if (perr[0] === 1'b1) perr_cnt++;
            if ({perr[1], ferr, ovr} !== 5'h00) bad_cnt++;
        end
    endtask

    always @(posedge lnk.dev_rts) fr_at = frames[1];

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // ====================================================
    // main sequence
    initial begin
        int m;
        tx_v = 2'b00;
        rx_r = 2'b11;
        pen = 2'b00;
        podd = 2'b00;
        tx_d[0] = 8'h00;
        tx_d[1] = 8'h00;
        reset_n_i = 1'b0;
        fork
            mon(0);
            mon(1);
            popper(0);
            popper(1);
            flags();
        join_none
        tick(6, 1);
        reset_n_i = 1'b1;
        cmp("idle_lines", 4'b1100, {lnk.d2h_txd, lnk.h2d_txd, lnk.dev_rts, lnk.host_cts});
        for (m = 0; m < 3; m++) begin
            pen = {2{m != 0}};
            podd = {2{m == 2}};
            fork
                burst(0, 6);
                burst(1, 6);
            join
            drain();
        end
        // host stalls its receiver, device must hold off
        rx_r[1] = 1'b0;
        burst(0, 12);
        tick(300, 1);
        cmp("host_cts", 1, lnk.host_cts);
        cmp("d2h_held", 1, lnk.d2h_txd);
        rx_r[1] = 1'b1;
        drain();
        // device stalls, host fifo fills until it refuses
        rx_r[0] = 1'b0;
        base = frames[1];
        burst(1, 24);
        cmp("host_tx_full", 0, tx_rdy[1]);
        tick(300, 1);
        cmp("dev_rts", 1, lnk.dev_rts);
        cmp("rts_level", 1, (fr_at - base) inside {16, 17});
        cmp("after_rts", 1, frames[1] - fr_at <= 16);
        rx_r[0] = 1'b1;
        drain();
        // parity disagreement: byte kept, one error pulse
        pen = 2'b11;
        podd = 2'b10;
        burst(1, 1);
        drain();
        cmp("perr_pulses", 1, perr_cnt);
        cmp("other_flags", 0, bad_cnt);
        stop_test();
    end
endmodule
